// ==== nfmem_pkg.sv ====
/*
  nfmem_pkg: shared constants for the frame memory setup and noise filter core.
  Assumes a single 125 MHz clock and a control register written over the serial control bus.
*/
package nfmem_pkg;
  // control register address on the serial control bus
  localparam logic [7:0] FMC_ADDR      = 8'h59;
  localparam logic [7:0] FMC_RESET     = 8'h00;
  // field positions
  localparam int         GEOM_LSB      = 0;
  localparam int         ENABLE_BIT    = 2;
  localparam int         DELAY_LSB     = 3;
  localparam int         DELAY_W       = 4;
  // chroma processing register and its two feature enable bits
  localparam logic [7:0] CPC_ADDR      = 8'h0D;
  localparam int         TNR_BIT       = 2;
  localparam int         YCS_BIT       = 3;
  // delay step in picoseconds
  localparam int         DELAY_STEP_PS = 580;
  // geometry figures
  localparam int         ROWS_SMALL    = 2048;
  localparam int         ROWS_LARGE    = 4096;
  localparam int         COLS          = 256;
  localparam int         COL_W         = 8;
  localparam int         ROW_W         = 12;
  localparam int         BANK_W        = 2;
  localparam int         PIX_W         = 8;
  localparam int         FIFO_DEPTH    = 16;
  // controller states
  typedef enum logic [1:0] {
    NFMEM_IDLE = 2'b00,
    NFMEM_RUN  = 2'b01,
    NFMEM_WRAP = 2'b11
  } nfmem_state_t;
endpackage

// ==== nfmem_fifo.sv ====
/*
  nfmem_fifo: synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module nfmem_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];    // storage
  logic [AW-1:0]    wr_ptr_r;       // write index
  logic [AW-1:0]    rd_ptr_r;       // read index
  logic [AW:0]      count_r;        // fill level
  logic             push;
  logic             pop;

  // honest full and empty
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_r];

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + AW'(1);
      if (pop)  rd_ptr_r <= rd_ptr_r + AW'(1);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== nfmem_core.sv ====
/*
  nfmem_core: frame memory control register, address geometry and coring filter.
  Assumes register writes arrive as a one-cycle strobe from the serial control bus
  decoder, pixels arrive on the ref_clk domain, and software keeps its own ordering.
*/
`timescale 1ns/100ps
`default_nettype none
module nfmem_core
  import nfmem_pkg::*;
#(
  parameter int PW = nfmem_pkg::PIX_W
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // register port
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  // noise measurement
  input  wire logic [7:0]                  noise_level,
  // pixel input stream
  input  wire logic                        pix_valid,
  output logic                             pix_ready,
  input  wire logic [PW-1:0]               pix_in,
  input  wire logic [PW-1:0]               pix_prev,
  // filtered output stream
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output logic      [PW-1:0]               out_pix,
  // memory address and clock control
  output logic                             mem_enable,
  output logic      [nfmem_pkg::BANK_W-1:0] mem_bank,
  output logic      [nfmem_pkg::ROW_W-1:0]  mem_row,
  output logic      [nfmem_pkg::COL_W-1:0]  mem_col,
  output logic      [nfmem_pkg::DELAY_W-1:0] mem_clk_delay,
  output logic                             filter_active
);
  import nfmem_pkg::*;

  logic [7:0]         ctrl_r;          // frame memory control register
  logic [7:0]         chroma_r;        // chroma processing register
  logic [1:0]         geom;            // geometry select
  logic [BANK_W-1:0]  bank_r;          // bank counter
  logic [ROW_W-1:0]   row_r;           // row counter
  logic [COL_W-1:0]   col_r;           // column counter
  logic [PW-1:0]      lo_thr;          // lower coring threshold
  logic [PW:0]        hi_thr;          // upper coring threshold
  logic [PW-1:0]      diff;            // absolute pixel difference
  logic [PW-1:0]      res_nxt;         // filter result
  logic               adv;             // one pixel accepted
  logic               fifo_in_ready;   // fifo space
  nfmem_state_t       state_r;         // controller state

  // bank count minus one for a geometry code
  function automatic logic [BANK_W-1:0] last_bank(input logic [1:0] g);
    last_bank = g[0] ? 2'h3 : 2'h1;
  endfunction
  // row count minus one for a geometry code
  function automatic logic [ROW_W-1:0] last_row(input logic [1:0] g);
    last_row = g[1] ? 12'(ROWS_LARGE - 1) : 12'(ROWS_SMALL - 1);
  endfunction

  assign geom          = ctrl_r[GEOM_LSB +: 2];
  assign mem_enable    = ctrl_r[ENABLE_BIT];
  assign mem_clk_delay = ctrl_r[DELAY_LSB +: DELAY_W];
  // feature live only when memory is enabled
  assign filter_active = mem_enable && (chroma_r[TNR_BIT] || chroma_r[YCS_BIT]);
  assign mem_bank      = bank_r;
  assign mem_row       = row_r;
  assign mem_col       = col_r;
  assign pix_ready     = fifo_in_ready;
  assign adv           = pix_valid && fifo_in_ready;

  // register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r   <= FMC_RESET;
      chroma_r <= 8'h00;
    end else if (reg_wr) begin
      // bit 7 reserved and read as zero, bits 6:3 hold the delay
      if (reg_addr == FMC_ADDR) ctrl_r <= {1'b0, reg_wdata[6:0]};
      if (reg_addr == CPC_ADDR) chroma_r <= reg_wdata;
    end
  end

  // register reads, reserved bits zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        FMC_ADDR: reg_rdata <= ctrl_r;
        CPC_ADDR: reg_rdata <= chroma_r;
        default:  reg_rdata <= 8'h00;
      endcase
    end
  end

  // controller state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= NFMEM_IDLE;
    end else begin
      case (state_r)
        NFMEM_IDLE: if (mem_enable) state_r <= NFMEM_RUN;
        NFMEM_RUN: begin
          if (!mem_enable) state_r <= NFMEM_IDLE;
          else if (adv && col_r == 8'(COLS - 1) && row_r == last_row(geom)
                   && bank_r == last_bank(geom)) state_r <= NFMEM_WRAP;
        end
        NFMEM_WRAP: state_r <= mem_enable ? NFMEM_RUN : NFMEM_IDLE;
        default: state_r <= NFMEM_IDLE;
      endcase
    end
  end

  // address walk bounded by geometry, extra rows and banks left unused
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bank_r <= '0;
      row_r  <= '0;
      col_r  <= '0;
    end else if (state_r != NFMEM_RUN) begin
      bank_r <= '0;
      row_r  <= '0;
      col_r  <= '0;
    end else if (reg_wr && reg_addr == FMC_ADDR) begin
      // a new geometry restarts the walk so no address outlives it
      bank_r <= '0;
      row_r  <= '0;
      col_r  <= '0;
    end else if (adv) begin
      col_r <= col_r + 8'h01;
      if (col_r == 8'(COLS - 1)) begin
        if (row_r == last_row(geom)) begin
          row_r  <= '0;
          bank_r <= (bank_r == last_bank(geom)) ? '0 : bank_r + 2'h1;
        end else begin
          row_r <= row_r + 12'h001;
        end
      end
    end
  end

  // thresholds follow noise; upper is twice lower
  assign lo_thr = noise_level;
  assign hi_thr = {lo_thr, 1'b0};
  assign diff   = (pix_in > pix_prev) ? pix_in - pix_prev : pix_prev - pix_in;

  // coring gain: three-quarter recursion at or below lower, halfway between, pass above upper
  always_comb begin
    res_nxt = pix_in;
    if (!filter_active || {1'b0, diff} > hi_thr) begin
      res_nxt = pix_in;
    end else if (diff <= lo_thr) begin
      // two guard bits so four full-scale pixels do not wrap
      res_nxt = PW'(({2'b00, pix_in} + {2'b00, pix_prev} + {2'b00, pix_prev}
                + {2'b00, pix_prev}) >> 2);
    end else begin
      res_nxt = PW'(({1'b0, pix_in} + {1'b0, pix_prev}) >> 1);
    end
  end

  // output buffer
  nfmem_fifo #(
    .WIDTH (PW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (pix_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (res_nxt),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_pix)
  );

  // checks
  property p_en_reset;
    @(posedge ref_clk) $fell(rst) |-> !mem_enable;
  endproperty
  a_en_reset: assert property (p_en_reset) else $error("enable not low after reset");

  property p_write_en;
    @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == FMC_ADDR |=> mem_enable == $past(reg_wdata[ENABLE_BIT]);
  endproperty
  a_write_en: assert property (p_write_en) else $error("enable write lost");

  property p_delay;
    @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == FMC_ADDR |=> mem_clk_delay == $past(reg_wdata[6:3]);
  endproperty
  a_delay: assert property (p_delay) else $error("delay field wrong");

  property p_rows;
    @(posedge ref_clk) disable iff (rst) !geom[1] |-> row_r < 12'(ROWS_SMALL);
  endproperty
  a_rows: assert property (p_rows) else $error("row beyond geometry");

  property p_banks;
    @(posedge ref_clk) disable iff (rst) !geom[0] |-> bank_r < 2'h2;
  endproperty
  a_banks: assert property (p_banks) else $error("bank beyond geometry");

  property p_pass;
    @(posedge ref_clk) disable iff (rst)
      filter_active && {1'b0, diff} > hi_thr |-> res_nxt == pix_in;
  endproperty
  a_pass: assert property (p_pass) else $error("large difference not passed");

  property p_core;
    @(posedge ref_clk) disable iff (rst)
      filter_active && diff <= lo_thr && diff > 8'h03 |-> res_nxt != pix_in;
  endproperty
  a_core: assert property (p_core) else $error("small difference not cored");

  property p_double;
    @(posedge ref_clk) disable iff (rst)
      filter_active && diff > lo_thr && diff > 8'h01
      && 10'(diff) <= 10'(lo_thr) * 10'h002 |-> res_nxt != pix_in;
  endproperty
  a_double: assert property (p_double) else $error("upper not twice lower");
endmodule
`default_nettype wire

// ==== nfmem_sink.sv ====
/*
  nfmem_sink: far-side consumer of the filtered pixel stream.
  Assumes the bench drives stall and that every transfer happens on a rising ref_clk edge.
*/
`timescale 1ns/100ps
`default_nettype none
module nfmem_sink (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // stream from the block
  input  wire logic        out_valid,
  output logic             out_ready,
  input  wire logic [7:0]  out_pix,
  // bench control and capture
  input  wire logic        stall,
  output logic      [7:0]  rx_pix,
  output logic      [15:0] rx_cnt
);
  // ready drops while the bench holds a stall
  assign out_ready = !stall;
  // capture each accepted pixel and count it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_pix <= 8'h00;
      rx_cnt <= 16'h0000;
    end else if (out_valid && out_ready) begin
      rx_pix <= out_pix;
      rx_cnt <= rx_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== nfmem_core_tb.sv ====
/*
  nfmem_core_tb: register, coring, geometry and buffer tests of nfmem_core.
  Assumes inputs change 1 ns after the rising edge and the sink model drains the output.
*/
`timescale 1ns/100ps
`default_nettype none
module nfmem_core_tb;
  import nfmem_pkg::*;
  logic        ref_clk, rst, reg_wr, reg_rd, pix_valid, pix_ready, stall;
  logic        out_valid, out_ready, mem_enable, filter_active;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, noise_level, pix_in, pix_prev, out_pix, rx_pix;
  logic [1:0]  mem_bank, bmax;
  logic [11:0] mem_row, rmax;
  logic [7:0]  mem_col, cmax;
  logic [3:0]  mem_clk_delay;
  logic [15:0] rx_cnt, n0;
  int          n_errors, checks_done, n;

  nfmem_core #(.PW(8)) i_nfmem_core (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .noise_level(noise_level), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_in(pix_in), .pix_prev(pix_prev), .out_valid(out_valid), .out_ready(out_ready),
    .out_pix(out_pix), .mem_enable(mem_enable), .mem_bank(mem_bank), .mem_row(mem_row),
    .mem_col(mem_col), .mem_clk_delay(mem_clk_delay), .filter_active(filter_active));
  nfmem_sink i_nfmem_sink (.ref_clk(ref_clk), .rst(rst), .out_valid(out_valid),
    .out_ready(out_ready), .out_pix(out_pix), .stall(stall), .rx_pix(rx_pix), .rx_cnt(rx_cnt));

  // free-running 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // highest address seen while the controller runs
  always @(posedge ref_clk) begin
    if (mem_enable === 1'b1) begin
      if (mem_bank > bmax) bmax = mem_bank;
      if (mem_row > rmax) rmax = mem_row;
      if (mem_col > cmax) cmax = mem_col;
    end
  end
  // one compare for every result
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // counts, verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask
  // one-cycle read strobe, data compared once registered
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    reg_rd = 1'b1; reg_addr = a;
    tick;
    reg_rd = 1'b0;
    tick;
    chk(what, exp, reg_rdata);
  endtask
  // hold a pixel until it is taken, bounded
  task automatic push(input logic [7:0] a, input logic [7:0] b);
    int   k;
    logic took;
    k = 0;
    took = 1'b0;
    pix_valid = 1'b1; pix_in = a; pix_prev = b;
    // ready is read while settled, before the edge that takes the pixel
    while (k < 40 && !took) begin
      took = (pix_ready === 1'b1);
      @(posedge ref_clk);
      k++;
    end
    #1;
    pix_valid = 1'b0;
    tick;
    if (!took) begin n_errors++; conclude; end
  endtask
  // send one pixel pair and compare what the sink receives
  task automatic pxl(input logic [7:0] a, b, exp, input string what);
    int k;
    n0 = rx_cnt;
    push(a, b);
    for (k = 0; k < 40 && rx_cnt === n0; k++) tick;
    if (rx_cnt === n0) begin n_errors++; conclude; end
    chk(what, exp, rx_pix);
  endtask

  initial begin
    {rst, reg_wr, reg_rd, pix_valid, stall} = 5'b10000;
    {reg_addr, reg_wdata, pix_in, pix_prev} = 32'h0000_0000;
    noise_level = 8'h08;
    n_errors = 0; checks_done = 0;
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'b0;
    // reset state, counters idle while disabled
    rd(FMC_ADDR, FMC_RESET, "ctl_reset");
    rd(CPC_ADDR, 8'h00, "cpc_reset");
    chk("delay_reset", 24'h0, mem_clk_delay);
    repeat (4) push(8'h10, 8'h10);
    chk("addr_idle", 24'h0, {mem_enable, mem_bank, mem_row, mem_col});
    $display("test reset done");
    // field widths, reserved bits, unmapped place
    wr(FMC_ADDR, 8'hFF);
    rd(FMC_ADDR, 8'h7F, "ctl_rw");
    chk("delay_max", 24'hF, mem_clk_delay);
    wr(FMC_ADDR, 8'h18);
    chk("delay_step", 24'h3, mem_clk_delay);
    chk("enable_off", 24'h0, mem_enable);
    rd(8'h5A, 8'h00, "unmapped");
    $display("test fields done");
    // enable, then temporal features
    wr(FMC_ADDR, 8'h04);
    chk("enable_on", 24'h1, mem_enable);
    chk("feature_off", 24'h0, filter_active);
    wr(CPC_ADDR, 8'h08);
    chk("sep_on", 24'h1, filter_active);
    wr(CPC_ADDR, 8'h04);
    chk("nr_on", 24'h1, filter_active);
    $display("test enable done");
    // coring against difference, lower threshold 8, then 16, 255 and 4
    pxl(8'h48, 8'h40, 8'h42, "core_low");
    pxl(8'h38, 8'h40, 8'h3E, "core_neg");
    pxl(8'h50, 8'h40, 8'h48, "core_high");
    pxl(8'h51, 8'h40, 8'h51, "pass_edge");
    pxl(8'h54, 8'h40, 8'h54, "pass_far");
    noise_level = 8'h10;
    pxl(8'h54, 8'h40, 8'h4A, "core_grown");
    noise_level = 8'hFF;
    pxl(8'hFF, 8'hF0, 8'hF3, "core_wide");
    pxl(8'h54, 8'h40, 8'h45, "limit_max");
    noise_level = 8'h04;
    pxl(8'h54, 8'h40, 8'h54, "limit_low");
    $display("test coring done");
    // every geometry code keeps the address inside it
    for (int g = 0; g < 4; g++) begin
      wr(FMC_ADDR, 8'h04 | 8'(g));
      bmax = 2'h0; rmax = 12'h000; cmax = 8'h00;
      repeat (300) push(8'h20, 8'h20);
      chk("bank_lim", 24'h1, bmax < (g[0] ? 4 : 2));
      chk("row_lim", 24'h1, rmax < (g[1] ? ROWS_LARGE : ROWS_SMALL));
      chk("addr_moves", 24'h1, (bmax | rmax | cmax) != 0);
      chk("addr_walk", 24'h00012C, {mem_bank, mem_row, mem_col});
    end
    $display("test geometry done");
    // fill against a stalled sink, then drain
    stall = 1'b1;
    pix_valid = 1'b1;
    n = 0;
    repeat (24) begin
      if (pix_ready === 1'b1) n++;
      tick;
    end
    pix_valid = 1'b0;
    chk("fill", 24'(FIFO_DEPTH), 24'(n));
    n0 = rx_cnt;
    stall = 1'b0;
    repeat (40) tick;
    chk("drain", 24'(n0 + 16'(FIFO_DEPTH)), 24'(rx_cnt));
    chk("empty", 24'h0, out_valid);
    $display("test buffer done");
    conclude;
  end
  // guard against a hang
  initial begin
    #700000;
    n_errors++;
    conclude;
  end
endmodule
`default_nettype wire
